// >>> common/msec_pkg.sv
// Purpose: Shared constants and carrier types of the misc sense/enable/cascade block.
// Assumes: One 50 MHz system clock; register port with one-cycle read latency.
// Notes: Offsets are word indexes on the plain register port.
package msec_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_PS = 20000;
    localparam int unsigned RST_HOLD_NS = 160;
    localparam int unsigned RST_DONE_NS = 960;
    localparam int unsigned SENSE_MIN_NS = 160;
    // Least times round up to whole cycles.
    localparam int unsigned SENSE_CYC = (SENSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RST_DONE_CYC = (RST_DONE_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 6;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFF_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_USER = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h5;

    // Mode register fields.
    localparam int unsigned MODE_RUN_BIT = 0;
    localparam int unsigned MODE_CASC_BIT = 1;
    localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
    localparam logic [DATA_W-1:0] MODE_MASK = 8'h03;

    // User register fields.
    localparam int unsigned USER_SENSE0_BIT = 0;
    localparam int unsigned USER_SENSE1_BIT = 1;
    localparam int unsigned USER_EN0_BIT = 2;
    localparam int unsigned USER_EN1_BIT = 3;
    localparam logic [DATA_W-1:0] USER_RST = 8'h00;

    // Interrupt status fields: two sense events and cascade released.
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_CASC_BIT = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    localparam int unsigned NSENSE = 2;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } msec_req_s;

    typedef enum logic [2:0] {
        CASC_IDLE = 3'b001,
        CASC_WAIT_JK = 3'b010,
        CASC_READY = 3'b100
    } msec_casc_e;

endpackage

// >>> hw/msec_sense.sv
// Purpose: Synchronise one sense input and report when it held for the least time.
// Assumes: Input is asynchronous to clk_sys_i.
// Notes: Emits a one-cycle hit pulse per assertion that lasts the least time; shorter assertions give none.
`timescale 1ns/1ps
`default_nettype none
module msec_sense (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Pin and event
    input wire logic pin_i,
    output logic hit_o
);
    import msec_pkg::*;

    logic sync1_q;
    logic sync2_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic hit_q;
    // The count rests one past the hit value, so a long assertion gives a single hit.
    wire long_enough = (cnt_q == CNT_W'(SENSE_CYC));

    // Count only the synchronised level so the first stage stays private.
    assign cnt_d = !sync2_q ? '0 : (long_enough ? cnt_q : cnt_q + 1'b1);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            cnt_q <= '0;
            hit_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            cnt_q <= cnt_d;
            hit_q <= sync2_q && (cnt_q == CNT_W'(SENSE_CYC - 1));
        end
    end

    assign hit_o = hit_q;
endmodule
`default_nettype wire

// >>> hw/msec_top.sv
// Purpose: Reset, user sense/enable register, cascade ready handshake, interrupt.
// Assumes: Register port strobes are one cycle, synchronous to clk_sys_i.
// Notes: Open-drain pins are split into output and output enable.
// Contract
// - Reset clears every internal register except the cascade state, which loads one-hot idle (3'b001).
// - Internal reset completes within 960 ns and users wait that long.
// - Reset puts mode bit 0 to zero, which is stop mode.
// - Sense bit 0 sets after sense input 0 is high for 160 ns.
// - Sense bit 1 sets after sense input 1 is high for 160 ns.
// - A latched sense bit stays set until software clears it by a write.
// - Enable output 0 follows enable bit 0 at user register bit two.
// - Enable output 1 follows enable bit 1, here placed at bit three.
// - Cascade ready is released only with cascade mode set and a JK pair seen.
// - Cascade ready is open drain: pull low or release.
// - All logic runs from one byte clock.
// - An active-low open-drain interrupt flags any unmasked condition.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module msec_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Register port
    input wire logic [msec_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [msec_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [msec_pkg::DATA_W-1:0] reg_rdata_o,
    // User pins
    input wire logic sense_input_0_i,
    input wire logic sense_input_1_i,
    output logic enable_output_0_o,
    output logic enable_output_1_o,
    // Cascade
    input wire logic jk_seen_i,
    input wire logic cascade_start_i,
    output logic cascade_ready_o,
    output logic cascade_ready_oe_o,
    output logic cascade_run_o,
    // Status
    output logic stop_mode_o,
    output logic reset_busy_o,
    output logic irq_n_o,
    output logic irq_n_oe_o
);
    import msec_pkg::*;

    // ****************************************************************
    // Request decode
    // ****************************************************************
    msec_req_s req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    wire wr_mode = req.wr && (req.addr == OFF_MODE);
    wire wr_user = req.wr && (req.addr == OFF_USER);
    wire wr_clr = req.wr && (req.addr == OFF_IRQ_CLR);
    wire wr_en = req.wr && (req.addr == OFF_IRQ_EN);

    logic [DATA_W-1:0] mode_q;
    logic [DATA_W-1:0] user_q;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [DATA_W-1:0] rdata_q;
    logic [CNT_W-1:0] rcnt_q;
    logic cstart_q;
    msec_casc_e casc_q;
    msec_casc_e casc_d;

    // ****************************************************************
    // Sense qualification
    // ****************************************************************
    logic [NSENSE-1:0] sense_pin;
    logic [NSENSE-1:0] sense_hit;
    assign sense_pin = {sense_input_1_i, sense_input_0_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSENSE; gi++) begin : g_sense
            msec_sense u_sense (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .pin_i(sense_pin[gi]),
                .hit_o(sense_hit[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // User register
    // ****************************************************************
    // Sense bits: a new hit wins over a software write of zero, so no event
    // that lands in the clearing cycle is lost.
    logic [DATA_W-1:0] user_d;
    logic [NSENSE-1:0] sense_keep;
    assign sense_keep = wr_user ? req.wdata[NSENSE-1:0] & user_q[NSENSE-1:0]
                                : user_q[NSENSE-1:0];
    assign user_d = {
        wr_user ? req.wdata[DATA_W-1:USER_EN0_BIT] : user_q[DATA_W-1:USER_EN0_BIT],
        sense_keep | sense_hit
    };

    // ****************************************************************
    // Cascade handshake
    // ****************************************************************
    wire casc_mode = mode_q[MODE_CASC_BIT];

    always_comb begin
        casc_d = casc_q;
        case (casc_q)
            CASC_IDLE: begin
                if (casc_mode) begin
                    casc_d = CASC_WAIT_JK;
                end
            end
            CASC_WAIT_JK: begin
                if (!casc_mode) begin
                    casc_d = CASC_IDLE;
                end else if (jk_seen_i) begin
                    casc_d = CASC_READY;
                end
            end
            CASC_READY: begin
                if (!casc_mode) begin
                    casc_d = CASC_IDLE;
                end
            end
            default: begin
                casc_d = CASC_IDLE;
            end
        endcase
    end

    wire casc_rel_evt = (casc_q != CASC_READY) && (casc_d == CASC_READY);

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    logic [IRQ_W-1:0] evt;
    logic [IRQ_W-1:0] stat_d;
    assign evt = {casc_rel_evt, sense_hit};
    // Set wins over clear in the same cycle.
    assign stat_d = (stat_q & ~(wr_clr ? req.wdata[IRQ_W-1:0] : IRQ_RST)) | evt;

    // ****************************************************************
    // Read mux
    // ****************************************************************
    logic [DATA_W-1:0] rd_mux;
    assign rd_mux = (req.addr == OFF_MODE) ? mode_q :
                    (req.addr == OFF_USER) ? user_q :
                    (req.addr == OFF_IRQ_STAT) ? DATA_W'(stat_q) :
                    (req.addr == OFF_IRQ_EN) ? DATA_W'(irq_en_q) :
                    (req.addr == OFF_STATUS) ? DATA_W'({reset_busy_o, cstart_q,
                                                        casc_q == CASC_READY}) :
                    '0;

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Synchronous reset means every register leaves reset on the same edge.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_q <= MODE_RST;
            user_q <= USER_RST;
            stat_q <= IRQ_RST;
            irq_en_q <= IRQ_RST;
            rdata_q <= '0;
            casc_q <= CASC_IDLE;
            cstart_q <= 1'b0;
            rcnt_q <= '0;
        end else begin
            mode_q <= wr_mode ? (req.wdata & MODE_MASK) : mode_q;
            user_q <= user_d;
            stat_q <= stat_d;
            irq_en_q <= wr_en ? req.wdata[IRQ_W-1:0] : irq_en_q;
            rdata_q <= req.rd ? rd_mux : '0;
            casc_q <= casc_d;
            cstart_q <= cascade_start_i && (casc_q == CASC_READY);
            rcnt_q <= (rcnt_q == CNT_W'(RST_DONE_CYC)) ? rcnt_q : rcnt_q + 1'b1;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata_o = rdata_q;
    assign enable_output_0_o = user_q[USER_EN0_BIT];
    assign enable_output_1_o = user_q[USER_EN1_BIT];
    assign stop_mode_o = !mode_q[MODE_RUN_BIT];
    // Busy while the settle window runs; callers should not rely on the block yet.
    assign reset_busy_o = (rcnt_q != CNT_W'(RST_DONE_CYC));
    // Pull low until released; the wired node goes high only when all release.
    assign cascade_ready_o = 1'b0;
    assign cascade_ready_oe_o = (casc_q != CASC_READY);
    // Start only counts once this end released, guarding a premature start.
    assign cascade_run_o = cstart_q;
    assign irq_n_o = 1'b0;
    assign irq_n_oe_o = |(stat_q & irq_en_q);
endmodule
`default_nettype wire

// >>> sim/msec_properties.sv
// Purpose: Port assertions for msec_top.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound from the testbench file.
`timescale 1ns/1ps
`default_nettype none
module msec_properties (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Register port
    input wire logic [msec_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [msec_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    // Pins
    input wire logic enable_output_0_o,
    input wire logic enable_output_1_o,
    input wire logic jk_seen_i,
    input wire logic cascade_ready_o,
    input wire logic cascade_ready_oe_o,
    input wire logic stop_mode_o,
    input wire logic reset_busy_o,
    input wire logic irq_n_o,
    input wire logic irq_n_oe_o
);
    import msec_pkg::*;
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire logic user_wr = reg_wr_i && reg_addr_i == OFF_USER;
    en0_follow_a: assert property (user_wr |=>
        enable_output_0_o == $past(reg_wdata_i[USER_EN0_BIT]))
        else $error("enable 0 wrong");
    en1_follow_a: assert property (user_wr |=>
        enable_output_1_o == $past(reg_wdata_i[USER_EN1_BIT]))
        else $error("enable 1 wrong");
    en_hold_a: assert property (!user_wr |=>
        $stable({enable_output_0_o, enable_output_1_o}))
        else $error("enable moved");
    stop_mode_a: assert property (reg_wr_i && reg_addr_i == OFF_MODE |=>
        stop_mode_o == !$past(reg_wdata_i[MODE_RUN_BIT]))
        else $error("stop mode wrong");
    reset_vals_a: assert property ($fell(rst_i) |-> stop_mode_o &&
        cascade_ready_oe_o && !irq_n_oe_o && reset_busy_o &&
        !enable_output_0_o && !enable_output_1_o)
        else $error("reset state wrong");
    busy_span_a: assert property ($fell(rst_i) |->
        reset_busy_o ##47 reset_busy_o ##1 !reset_busy_o)
        else $error("reset busy span wrong");
    release_cause_a: assert property ($fell(cascade_ready_oe_o) |->
        $past(jk_seen_i)) else $error("ready released without pair");
    open_drain_a: assert property (cascade_ready_o == 1'b0 && irq_n_o == 1'b0)
        else $error("open drain level wrong");
    irq_mask_a: assert property (reg_wr_i && reg_addr_i == OFF_IRQ_EN &&
        reg_wdata_i == 8'h00 |=> !irq_n_oe_o) else $error("masked irq driven");
endmodule
`default_nettype wire

// >>> sim/msec_far.sv
// Purpose: External user logic and cascade synchroniser model.
// Assumes: Ready wire has a pull-up.
// Notes: Start is raised only while the ready wire is released.
`timescale 1ns/1ps
`default_nettype none
module msec_far (
    // Clock
    input wire logic clk_sys_i,
    // Bench commands
    input wire logic [1:0] sense_req_i,
    input wire logic jk_req_i,
    input wire logic go_i,
    // Device side
    input wire logic ready_oe_i,
    output logic sense_input_0_o,
    output logic sense_input_1_o,
    output logic jk_seen_o,
    output logic cascade_start_o
);
    // A released open-drain wire is pulled high, never left floating.
    wire logic ready_wire = (ready_oe_i === 1'b1) ? 1'b0 : 1'b1;
    assign sense_input_0_o = sense_req_i[0];
    assign sense_input_1_o = sense_req_i[1];
    assign jk_seen_o = jk_req_i;
    // Start settles at the first edge, which always falls inside reset.
    always @(posedge clk_sys_i) begin
        cascade_start_o <= go_i & ready_wire;
    end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: Self-checking bench for msec_top.
// Assumes: Register reads answer in the next cycle.
// Notes: Reset is applied twice to cover a mid-run reset.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import msec_pkg::*;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] reg_addr_i = 4'h0;
    logic [DATA_W-1:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [1:0] sense_req = 2'h0;
    logic jk_req = 1'b0;
    logic go = 1'b0;
    logic [DATA_W-1:0] reg_rdata_o;
    logic s0, s1, en0, en1, jk, start, rdy, rdy_oe, run, stop, busy, irq, irq_oe;
    int err_total = 0;
    int checked = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    msec_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sense_input_0_i(s0), .sense_input_1_i(s1),
        .enable_output_0_o(en0), .enable_output_1_o(en1), .jk_seen_i(jk),
        .cascade_start_i(start), .cascade_ready_o(rdy), .cascade_ready_oe_o(rdy_oe),
        .cascade_run_o(run), .stop_mode_o(stop), .reset_busy_o(busy), .irq_n_o(irq),
        .irq_n_oe_o(irq_oe));
    msec_far i_far (.clk_sys_i(clk_sys_i), .sense_req_i(sense_req), .jk_req_i(jk_req),
        .go_i(go), .ready_oe_i(rdy_oe), .sense_input_0_o(s0), .sense_input_1_o(s1),
        .jk_seen_o(jk), .cascade_start_o(start));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(what, exp, reg_rdata_o);
    endtask
    task automatic pulse_sense(input int i, input int n);
        @(posedge clk_sys_i);
        sense_req[i] <= 1'b1;
        cyc(n);
        sense_req[i] <= 1'b0;
        cyc(12);
    endtask
    task automatic t_reset;
        int n;
        n = 0;
        #1 chk("stop", 8'h01, {7'h00, stop});
        chk("ready_oe", 8'h01, {7'h00, rdy_oe});
        chk("busy", 8'h01, {7'h00, busy});
        // Look just after each edge so the count sees the value that edge launched.
        while (busy !== 1'b0 && n < 100) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        chk("busy_span", 8'(RST_DONE_CYC), 8'(n));
        rd(OFF_MODE, MODE_RST, "mode");
        rd(OFF_USER, USER_RST, "user");
        rd(OFF_IRQ_STAT, 8'h00, "stat");
        rd(OFF_IRQ_EN, 8'h00, "irq_en");
        $display("reset test done");
    endtask
    task automatic t_enable;
        logic [7:0] tbl [4] = '{8'h04, 8'h08, 8'h0C, 8'h00};
        foreach (tbl[k]) begin
            wr(OFF_USER, tbl[k]);
            chk("enables", {6'h00, tbl[k][3:2]}, {6'h00, en1, en0});
            rd(OFF_USER, tbl[k], "user");
        end
        $display("enable test done");
    endtask
    task automatic t_sense;
        // One sample short of the least time must be ignored, the least time must latch.
        for (int i = 0; i < 2; i++) begin
            pulse_sense(i, SENSE_CYC - 1);
            rd(OFF_USER, 8'h00, "short");
            pulse_sense(i, SENSE_CYC);
            rd(OFF_USER, 8'(1 << i), "sticky");
            rd(OFF_IRQ_STAT, 8'(1 << i), "stat");
            wr(OFF_USER, 8'h00);
            rd(OFF_USER, 8'h00, "cleared");
            wr(OFF_IRQ_CLR, 8'h07);
        end
        $display("sense test done");
    endtask
    task automatic t_irq;
        wr(OFF_IRQ_EN, 8'h01);
        pulse_sense(0, 14);
        #1 chk("irq", 8'h01, {7'h00, irq_oe});
        chk("irq_level", 8'h00, {7'h00, irq});
        wr(OFF_IRQ_EN, 8'h00);
        chk("masked", 8'h00, {7'h00, irq_oe});
        wr(OFF_IRQ_EN, 8'h01);
        wr(OFF_IRQ_STAT, 8'h00);
        chk("stat_ro", 8'h01, {7'h00, irq_oe});
        wr(OFF_IRQ_CLR, 8'h01);
        chk("irq_clr", 8'h00, {7'h00, irq_oe});
        rd(4'hF, 8'h00, "unmapped");
        wr(OFF_USER, 8'h00);
        $display("irq test done");
    endtask
    task automatic t_casc;
        @(posedge clk_sys_i);
        jk_req <= 1'b1;
        cyc(1);
        jk_req <= 1'b0;
        go <= 1'b1;
        wr(OFF_MODE, 8'h02);
        cyc(3);
        chk("held", 8'h01, {7'h00, rdy_oe});
        chk("no_run", 8'h00, {7'h00, run});
        jk_req <= 1'b1;
        cyc(1);
        jk_req <= 1'b0;
        cyc(4);
        chk("released", 8'h00, {7'h00, rdy_oe});
        chk("ready_level", 8'h00, {7'h00, rdy});
        chk("run", 8'h01, {7'h00, run});
        rd(OFF_STATUS, 8'h03, "status");
        rd(OFF_IRQ_STAT, 8'h04, "casc_stat");
        @(posedge clk_sys_i);
        go <= 1'b0;
        wr(OFF_MODE, 8'h01);
        cyc(2);
        chk("pull", 8'h01, {7'h00, rdy_oe});
        chk("run_mode", 8'h00, {7'h00, stop});
        $display("cascade test done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****************************************************************
    // Sequence and watchdog
    // ****************************************************************
    initial begin
        cyc(12);
        rst_i <= 1'b0;
        t_reset;
        t_enable;
        t_sense;
        t_irq;
        t_casc;
        rst_i <= 1'b1;
        cyc(12);
        rst_i <= 1'b0;
        t_reset;
        results();
    end
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule
bind msec_top msec_properties i_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .enable_output_0_o(enable_output_0_o), .enable_output_1_o(enable_output_1_o),
    .jk_seen_i(jk_seen_i), .cascade_ready_o(cascade_ready_o),
    .cascade_ready_oe_o(cascade_ready_oe_o), .stop_mode_o(stop_mode_o),
    .reset_busy_o(reset_busy_o), .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o));
`default_nettype wire
